// >>> tpg_pkg.sv
/*
 Constants, field layout and carrier types of the 8-bit timer with PWM and
 comparator gate. Assumes one clock (hclk, 100 MHz) and an AHB-Lite register bus.
*/
// Contract
// - Control bits 3:1 pick comparator negative input
// - Control bit 0 picks comparator positive input
// - Select bit 7 forces result onto pin
// - Result direct or sampled on timer tick
// - Control bit 4 inverts comparator result
// - Result raises request, reads as bit 6
// - Select bits 5:4 range, 3:0 tap
// - Timer control bits 7:4 pick clock source
// - Timer control bits 3:2 route output pin
// - Selected timer pin forced regardless of direction
// - Scale bits 6:5 prescale by 1,4,16,64
// - Scale bits 4:0 scaler makes the tick
// - Eight-bit up counter, one step per tick
// - Count register writable and readable
// - Counter clears to zero at bound in period mode
// - Period mode and PWM mode exist
// - PWM resolution six or eight bits
// - Gate option stops PWM while result is 1
// - Period mode toggles, half duty
// - 8-bit PWM: period 256, high bound+1
// - 6-bit PWM: period 64, high bound+1
package tpg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMP_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMP_SEL = 8'h04;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h08;
  localparam logic [7:0] OFS_TMR_SCALE = 8'h0c;
  localparam logic [7:0] OFS_TMR_COUNT = 8'h10;
  localparam logic [7:0] OFS_TMR_BOUND = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Comparator control fields
  localparam int CC_POS = 0;
  localparam int CC_NEG_LSB = 1;
  localparam int CC_INV = 4;
  localparam int CC_SAMPLE = 5;
  localparam int CC_RESULT = 6;
  localparam int CC_EN = 7;
  // Comparator select fields
  localparam int CS_TAP_LSB = 0;
  localparam int CS_RANGE_LSB = 4;
  localparam int CS_FORCE = 7;
  // Timer control fields
  localparam int TC_PWM = 1;
  localparam int TC_PIN_LSB = 2;
  localparam int TC_SRC_LSB = 4;
  // Timer scale fields
  localparam int TS_SCL_LSB = 0;
  localparam int TS_PRE_LSB = 5;
  localparam int TS_SIX = 7;
  // Status fields
  localparam int ST_TMR = 0;
  localparam int ST_CMP = 1;
  // Clock source codes
  localparam logic [3:0] SRC_STOP = 4'h0;
  localparam logic [3:0] SRC_SYS = 4'h1;
  localparam logic [3:0] SRC_FAST = 4'h2;
  localparam logic [3:0] SRC_SLOW = 4'h3;
  localparam logic [3:0] SRC_XTAL = 4'h4;
  localparam logic [3:0] SRC_CMP = 4'h5;
  localparam logic [3:0] SRC_LINE_A0 = 4'h6;
  localparam logic [3:0] SRC_LINE_B0 = 4'h7;
  localparam logic [3:0] SRC_LINE_A4 = 4'h8;
  // Synchronised inputs
  localparam int SY_FAST = 0;
  localparam int SY_SLOW = 1;
  localparam int SY_XTAL = 2;
  localparam int SY_LINE_A0 = 3;
  localparam int SY_LINE_B0 = 4;
  localparam int SY_LINE_A4 = 5;
  localparam int SY_CMP = 6;
  localparam int SYNC_W = 7;
  // Shared pins: forced comparator pin, then three timer pins
  localparam int PIN_W = 4;
  localparam int PIN_CMP = 0;
  // Prescaler terminal counts for divide by 1, 4, 16, 64
  localparam logic [5:0] PRE_MAX1 = 6'h00;
  localparam logic [5:0] PRE_MAX4 = 6'h03;
  localparam logic [5:0] PRE_MAX16 = 6'h0f;
  localparam logic [5:0] PRE_MAX64 = 6'h3f;

  typedef struct packed {
    logic enable;
    logic [2:0] neg_sel;
    logic pos_sel;
    logic [1:0] range;
    logic [3:0] tap;
  } tpg_cmp_ctrl_t;

  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe_n;
  } tpg_pins_t;
endpackage

// >>> tpg_sync.sv
/*
 Two-flop synchroniser for the asynchronous clock sources, pins and the
 comparator. Assumes inputs may change at any time relative to hclk.
*/
`timescale 1ns/100ps
module tpg_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [tpg_pkg::SYNC_W-1:0] async_in,
  output logic [tpg_pkg::SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [tpg_pkg::SYNC_W-1:0] s1;
    logic [tpg_pkg::SYNC_W-1:0] s2;
  } tpg_sync_state_t;

  tpg_sync_state_t s;
  tpg_sync_state_t next_s;

  always_comb begin
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.s2;
endmodule

// >>> tpg_tick.sv
/*
 Prescaler and scaler cascade that turns source pulses into the timer tick.
 Assumes src_pulse is a one-cycle pulse per rising edge of the selected source.
*/
`timescale 1ns/100ps
module tpg_tick (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic src_pulse,
  input wire logic [1:0] pre_sel,
  input wire logic [4:0] scale,
  output logic tick
);
  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [4:0] scl_cnt;
    logic tick;
  } tpg_tick_state_t;

  tpg_tick_state_t s;
  tpg_tick_state_t next_s;
  logic [5:0] pre_max;

  always_comb begin
    case (pre_sel)
      2'h0: pre_max = tpg_pkg::PRE_MAX1;
      2'h1: pre_max = tpg_pkg::PRE_MAX4;
      2'h2: pre_max = tpg_pkg::PRE_MAX16;
      default: pre_max = tpg_pkg::PRE_MAX64;
    endcase
    next_s = s;
    next_s.tick = 1'b0;
    if (src_pulse) begin
      if (s.pre_cnt >= pre_max) begin
        next_s.pre_cnt = 6'h00;
        if (s.scl_cnt >= scale) begin
          next_s.scl_cnt = 5'h00;
          next_s.tick = 1'b1;
        end else begin
          next_s.scl_cnt = s.scl_cnt + 5'h01;
        end
      end else begin
        next_s.pre_cnt = s.pre_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// >>> tpg_timer.sv
/*
 Top of the 8-bit timer with period and PWM modes, comparator gating and the
 comparator's digital control. Assumes an AHB-Lite master on hclk, analog
 comparator and oscillators outside, and a port block that supplies its own
 pin drive which this block overrides when forcing.
*/
`timescale 1ns/100ps
module tpg_timer #(
  parameter bit GATE_EN = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  input wire logic crystal_osc,
  input wire logic port_a_line0,
  input wire logic port_b_line0,
  input wire logic port_a_line4,
  input wire logic cmp_raw,
  input wire tpg_pkg::tpg_pins_t port_drive,
  output tpg_pkg::tpg_pins_t pin_drive,
  output tpg_pkg::tpg_cmp_ctrl_t cmp_ctrl,
  output logic compare_gated_pwm,
  output logic timer_a_irq,
  output logic cmp_irq
);
  typedef struct packed {
    logic [7:0] cmp_ctl;
    logic [7:0] cmp_sel;
    logic [7:0] tmr_ctrl;
    logic [7:0] tmr_scale;
    logic [7:0] tmr_count;
    logic [7:0] tmr_bound;
    logic [1:0] status;
    logic cmp_held;
    logic cmp_prev;
    logic wave;
    logic [tpg_pkg::SYNC_W-1:0] src_prev;
    logic dp_write;
    logic [7:0] dp_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    tpg_pkg::tpg_pins_t pins;
    tpg_pkg::tpg_cmp_ctrl_t cmp_out;
    logic gated;
    logic timer_irq;
    logic cmp_irq;
  } tpg_state_t;

  tpg_state_t s;
  tpg_state_t next_s;
  logic [tpg_pkg::SYNC_W-1:0] sync_in;
  logic [tpg_pkg::SYNC_W-1:0] sync_q;
  logic [tpg_pkg::SYNC_W-1:0] rise;
  logic src_pulse;
  logic tick;
  logic cmp_live;
  logic cmp_res;
  logic six_bit;
  logic pwm_mode;
  logic pwm_high;
  logic wave_now;
  logic [1:0] pin_sel;
  logic addr_ok;
  logic [7:0] wr;

  assign sync_in = {cmp_raw, port_a_line4, port_b_line0, port_a_line0,
                    crystal_osc, slow_internal_osc, fast_internal_osc};

  tpg_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  tpg_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_pulse(src_pulse),
    .pre_sel(s.tmr_scale[tpg_pkg::TS_PRE_LSB +: 2]),
    .scale(s.tmr_scale[tpg_pkg::TS_SCL_LSB +: 5]),
    .tick(tick)
  );

  function automatic logic [7:0] read_reg(input logic [7:0] a, input tpg_state_t st,
                                          input logic res);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      tpg_pkg::OFS_CMP_CTRL: begin
        v = st.cmp_ctl;
        v[tpg_pkg::CC_RESULT] = res;
      end
      tpg_pkg::OFS_CMP_SEL: v = st.cmp_sel;
      tpg_pkg::OFS_TMR_CTRL: v = st.tmr_ctrl;
      tpg_pkg::OFS_TMR_SCALE: v = st.tmr_scale;
      tpg_pkg::OFS_TMR_COUNT: v = st.tmr_count;
      tpg_pkg::OFS_TMR_BOUND: v = st.tmr_bound;
      tpg_pkg::OFS_STATUS: v = {6'h00, st.status};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    // Edge pulses of synchronised sources
    rise = sync_q & ~s.src_prev;
    // Comparator result path
    cmp_live = sync_q[tpg_pkg::SY_CMP] ^ s.cmp_ctl[tpg_pkg::CC_INV];
    cmp_res = s.cmp_ctl[tpg_pkg::CC_SAMPLE] ? s.cmp_held : cmp_live;
    // Clock source selection
    case (s.tmr_ctrl[tpg_pkg::TC_SRC_LSB +: 4])
      tpg_pkg::SRC_SYS: src_pulse = 1'b1;
      tpg_pkg::SRC_FAST: src_pulse = rise[tpg_pkg::SY_FAST];
      tpg_pkg::SRC_SLOW: src_pulse = rise[tpg_pkg::SY_SLOW];
      tpg_pkg::SRC_XTAL: src_pulse = rise[tpg_pkg::SY_XTAL];
      tpg_pkg::SRC_CMP: src_pulse = cmp_res & ~s.cmp_prev;
      tpg_pkg::SRC_LINE_A0: src_pulse = rise[tpg_pkg::SY_LINE_A0];
      tpg_pkg::SRC_LINE_B0: src_pulse = rise[tpg_pkg::SY_LINE_B0];
      tpg_pkg::SRC_LINE_A4: src_pulse = rise[tpg_pkg::SY_LINE_A4];
      default: src_pulse = 1'b0;
    endcase
    pwm_mode = s.tmr_ctrl[tpg_pkg::TC_PWM];
    six_bit = s.tmr_scale[tpg_pkg::TS_SIX];
    pin_sel = s.tmr_ctrl[tpg_pkg::TC_PIN_LSB +: 2];
    addr_ok = hsel & hready & htrans[1];
    wr = hwdata[7:0];

    next_s = s;
    next_s.src_prev = sync_q;
    next_s.cmp_prev = cmp_res;
    next_s.timer_irq = 1'b0;
    next_s.cmp_irq = 1'b0;
    next_s.hreadyout = 1'b1;

    if (tick && s.cmp_ctl[tpg_pkg::CC_SAMPLE]) begin
      next_s.cmp_held = cmp_live;
    end

    // Counter
    if (tick) begin
      if (pwm_mode) begin
        if (six_bit) begin
          next_s.tmr_count = {2'b00, s.tmr_count[5:0] + 6'h01};
        end else begin
          next_s.tmr_count = s.tmr_count + 8'h01;
        end
      end else if (s.tmr_count == s.tmr_bound) begin
        next_s.tmr_count = 8'h00;
        next_s.wave = ~s.wave;
        next_s.timer_irq = 1'b1;
      end else begin
        next_s.tmr_count = s.tmr_count + 8'h01;
      end
    end

    // PWM level from the counter value after this step
    if (six_bit) begin
      pwm_high = next_s.tmr_count[5:0] <= s.tmr_bound[5:0];
    end else begin
      pwm_high = next_s.tmr_count <= s.tmr_bound;
    end
    if (pwm_mode) begin
      next_s.wave = pwm_high;
      wave_now = pwm_high & ~(GATE_EN & cmp_res);
    end else begin
      wave_now = next_s.wave;
    end
    next_s.gated = wave_now;

    // Comparator request on rising result
    if (cmp_res && !s.cmp_prev) begin
      next_s.cmp_irq = 1'b1;
    end

    // Bus data phase writes
    if (s.dp_write) begin
      case (s.dp_addr)
        tpg_pkg::OFS_CMP_CTRL: next_s.cmp_ctl = wr;
        tpg_pkg::OFS_CMP_SEL: next_s.cmp_sel = wr;
        tpg_pkg::OFS_TMR_CTRL: next_s.tmr_ctrl = wr;
        tpg_pkg::OFS_TMR_SCALE: next_s.tmr_scale = wr;
        tpg_pkg::OFS_TMR_COUNT: next_s.tmr_count = wr;
        tpg_pkg::OFS_TMR_BOUND: next_s.tmr_bound = wr;
        tpg_pkg::OFS_STATUS: next_s.status = s.status & ~wr[1:0];
        default: next_s.status = next_s.status;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (next_s.timer_irq) begin
      next_s.status[tpg_pkg::ST_TMR] = 1'b1;
    end
    if (next_s.cmp_irq) begin
      next_s.status[tpg_pkg::ST_CMP] = 1'b1;
    end

    // Bus address phase
    next_s.dp_write = addr_ok & hwrite;
    next_s.dp_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      next_s.hrdata = {24'h000000, read_reg(haddr[7:0], s, cmp_res)};
    end

    // Comparator analog controls
    next_s.cmp_out.enable = s.cmp_ctl[tpg_pkg::CC_EN];
    next_s.cmp_out.neg_sel = s.cmp_ctl[tpg_pkg::CC_NEG_LSB +: 3];
    next_s.cmp_out.pos_sel = s.cmp_ctl[tpg_pkg::CC_POS];
    next_s.cmp_out.range = s.cmp_sel[tpg_pkg::CS_RANGE_LSB +: 2];
    next_s.cmp_out.tap = s.cmp_sel[tpg_pkg::CS_TAP_LSB +: 4];

    // Pin overrides
    next_s.pins = port_drive;
    if (s.cmp_sel[tpg_pkg::CS_FORCE]) begin
      next_s.pins.out[tpg_pkg::PIN_CMP] = cmp_res;
      next_s.pins.oe_n[tpg_pkg::PIN_CMP] = 1'b0;
    end
    if (pin_sel != 2'b00) begin
      next_s.pins.out[pin_sel] = wave_now;
      next_s.pins.oe_n[pin_sel] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cmp_ctl <= tpg_pkg::RST_REG;
      s.cmp_sel <= tpg_pkg::RST_REG;
      s.tmr_ctrl <= tpg_pkg::RST_REG;
      s.tmr_scale <= tpg_pkg::RST_REG;
      s.tmr_count <= tpg_pkg::RST_REG;
      s.tmr_bound <= tpg_pkg::RST_REG;
      s.pins.oe_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = 1'b0;
  assign pin_drive = s.pins;
  assign cmp_ctrl = s.cmp_out;
  assign compare_gated_pwm = s.gated;
  assign timer_a_irq = s.timer_irq;
  assign cmp_irq = s.cmp_irq;
endmodule

// >>> tpg_timer_assertions.sv
/*
 Port checker for tpg_timer: bus answer, comparator field copies, pin steering.
 Assumes one AHB-Lite master and that the bind below reaches every tpg_timer.
*/
`timescale 1ns/100ps
module tpg_timer_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire tpg_pkg::tpg_pins_t port_drive,
  input wire tpg_pkg::tpg_pins_t pin_drive,
  input wire tpg_pkg::tpg_cmp_ctrl_t cmp_ctrl,
  input wire logic compare_gated_pwm,
  input wire logic cmp_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ph;
  logic [7:0] pa;
  logic frc;
  logic [1:0] tpin;
  wire wq = hsel && hready && htrans[1] && hwrite;
  // Shadow of writes that steer the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 1'b0;
      pa <= 8'h00;
      frc <= 1'b0;
      tpin <= 2'h0;
    end else begin
      ph <= wq;
      pa <= haddr[7:0];
      if (ph && pa == tpg_pkg::OFS_CMP_SEL) begin
        frc <= hwdata[7];
      end
      if (ph && pa == tpg_pkg::OFS_TMR_CTRL) begin
        tpin <= hwdata[3:2];
      end
    end
  end
  a_neg_pos_copy: assert property (
    wq && haddr[7:0] == tpg_pkg::OFS_CMP_CTRL |-> ##3
    {cmp_ctrl.neg_sel, cmp_ctrl.pos_sel} == $past(hwdata[3:0], 2))
    else $error("comparator input select not copied");
  a_ladder_copy: assert property (
    wq && haddr[7:0] == tpg_pkg::OFS_CMP_SEL |-> ##3
    {cmp_ctrl.range, cmp_ctrl.tap} == $past(hwdata[5:0], 2))
    else $error("ladder range or tap not copied");
  a_cmp_irq_pulse: assert property (cmp_irq |=> !cmp_irq)
    else $error("comparator request longer than one cycle");
  a_force_pin: assert property (frc && $past(frc) |-> !pin_drive.oe_n[0])
    else $error("comparator pin not forced");
  a_timer_pin: assert property (
    tpin != 2'h0 && $past(tpin) == tpin |->
    !pin_drive.oe_n[tpin] && pin_drive.out[tpin] == compare_gated_pwm)
    else $error("timer pin not forced with waveform");
  a_pins_follow: assert property (
    $past(hresetn) && !frc && !$past(frc) && tpin == 2'h0 && $past(tpin) == 2'h0
    |-> pin_drive == $past(port_drive))
    else $error("unselected pins not passed through");
  a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("bus stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
endmodule
bind tpg_timer tpg_timer_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .port_drive(port_drive), .pin_drive(pin_drive),
  .cmp_ctrl(cmp_ctrl), .compare_gated_pwm(compare_gated_pwm), .cmp_irq(cmp_irq));

// >>> tpg_timer_tb.sv
/*
 Self-checking bench for tpg_timer, one task a scenario.
 Assumes tpg_pkg and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
module tpg_timer_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [6:0] sl = 7'h00;
  logic [6:0] tm = 7'h00;
  logic [1:0] dv = 2'h0;
  tpg_pkg::tpg_pins_t port_drive = 8'h5b;
  tpg_pkg::tpg_pins_t pin_drive;
  tpg_pkg::tpg_cmp_ctrl_t cmp_ctrl;
  logic wave;
  logic tirq;
  logic cirq;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int h, p, q, c;
  always #5 hclk = ~hclk;
  tpg_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .fast_internal_osc(sl[0]),
    .slow_internal_osc(sl[1]), .crystal_osc(sl[2]), .cmp_raw(sl[3]), .port_a_line0(sl[4]),
    .port_b_line0(sl[5]), .port_a_line4(sl[6]), .port_drive(port_drive),
    .pin_drive(pin_drive), .cmp_ctrl(cmp_ctrl), .compare_gated_pwm(wave),
    .timer_a_irq(tirq), .cmp_irq(cirq));
  // Source toggler, rising edge every 8 cycles
  always @(posedge hclk) begin
    dv <= dv + 2'h1;
    if (dv == 2'h3 && tm != 7'h00) begin
      sl <= sl ^ tm;
    end
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(hrdata, {24'h0, exp});
  endtask
  // High time, period and timer requests over one waveform period
  task meas;
    h = 0;
    q = 0;
    while (wave !== 1'b0) @(posedge hclk);
    while (wave !== 1'b1) @(posedge hclk);
    while (wave === 1'b1) begin
      h = h + 1;
      q = q + tirq;
      @(posedge hclk);
    end
    p = h;
    while (wave !== 1'b1) begin
      p = p + 1;
      q = q + tirq;
      @(posedge hclk);
    end
  endtask
  task hi;
    c = 0;
    repeat (128) begin
      @(posedge hclk);
      c = c + (wave === 1'b1);
    end
  endtask
  task t_regs;
    logic [23:0] tr [6] = '{24'h1cff00, 24'h043f3f, 24'h0cffff, 24'h145a5a, 24'h080f0f,
      24'h001050};
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
    foreach (tr[i]) begin
      wr(tr[i][23:16], tr[i][15:8]);
      rd(tr[i][23:16], tr[i][7:0]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 8'(i * 2 + i % 2));
      rd(8'h00, 8'(i * 2 + i % 2));
    end
    $display("registers done");
  endtask
  task t_count;
    logic [31:0] tc [3] = '{32'h5aff055f, 32'hfdff0300, 32'h0f100200};
    wr(8'h0c, 8'h00);
    wr(8'h08, 8'h60);
    foreach (tc[i]) begin
      wr(8'h14, tc[i][23:16]);
      wr(8'h10, tc[i][31:24]);
      repeat (tc[i][15:8]) begin
        sl[4] <= 1'b1;
        repeat (4) @(posedge hclk);
        sl[4] <= 1'b0;
        repeat (4) @(posedge hclk);
      end
      repeat (6) @(posedge hclk);
      rd(8'h10, tc[i][7:0]);
    end
    $display("counter done");
  endtask
  task t_period;
    int b [4] = '{1, 3, 0, 2};
    int e;
    wr(8'h18, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 8'(16 + i * 4));
      wr(8'h14, 8'(b[i]));
      wr(8'h10, 8'h00);
      wr(8'h0c, 8'(i * 32 + i % 3));
      meas();
      e = (b[i] + 1) * (1 << (2 * i)) * (i % 3 + 1);
      chk(h, e);
      chk(p, 2 * e);
      chk(q, 2);
    end
    rd(8'h18, 8'h01);
    $display("period done");
  endtask
  task t_pwm;
    logic [15:0] tp [3] = '{16'h0009, 16'h801f, 16'h8000};
    wr(8'h08, 8'h12);
    foreach (tp[i]) begin
      wr(8'h14, tp[i][7:0]);
      wr(8'h0c, tp[i][15:8]);
      meas();
      chk(h, tp[i][7:0] + 1);
      chk(p, tp[i][15] ? 64 : 256);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h0c, i ? 8'h80 : 8'h00);
      wr(8'h14, i ? 8'h3f : 8'hff);
      repeat (10) @(posedge hclk);
      hi();
      chk(c, 128);
    end
    $display("pwm done");
  endtask
  task t_gate;
    wr(8'h00, 8'h80);
    wr(8'h14, 8'h1f);
    sl[3] <= 1'b1;
    repeat (6) @(posedge hclk);
    hi();
    chk(c, 0);
    rd(8'h00, 8'hc0);
    sl[3] <= 1'b0;
    repeat (6) @(posedge hclk);
    meas();
    chk(h, 32);
    wr(8'h00, 8'h90);
    repeat (6) @(posedge hclk);
    hi();
    chk(c, 0);
    wr(8'h00, 8'h80);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'ha0);
    sl[3] <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(8'h00, 8'ha0);
    wr(8'h08, 8'h10);
    repeat (4) @(posedge hclk);
    rd(8'h00, 8'he0);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'hc0);
    sl[3] <= 1'b0;
    $display("gate done");
  endtask
  task t_src;
    wr(8'h0c, 8'h00);
    wr(8'h14, 8'h00);
    for (int k = 2; k < 9; k++) begin
      tm <= 7'(1 << (k - 2));
      wr(8'h08, 8'(k * 16 + (k % 3 + 1) * 4));
      meas();
      chk(h, 8);
      chk(p, 16);
      tm <= 7'h00;
      @(posedge hclk);
      sl <= 7'h00;
    end
    wr(8'h04, 8'h80);
    repeat (4) @(posedge hclk);
    rd(8'h04, 8'h80);
    chk({pin_drive.out[0], pin_drive.oe_n[0]}, 32'h0);
    $display("sources done");
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_count();
    t_period();
    t_pwm();
    t_gate();
    t_src();
    end_sim();
  end
endmodule
